// >>> vf_limit_params.svh
// constants for the frequency limit and v/f pattern block
`ifndef VF_LIMIT_PARAMS_SVH
`define VF_LIMIT_PARAMS_SVH
// register byte offsets
`define OFS_UPPER_LIMIT   8'h00
`define OFS_LOWER_LIMIT   8'h04
`define OFS_HS_UPPER      8'h08
`define OFS_JOG_FREQ      8'h0C
`define OFS_START_FREQ    8'h10
`define OFS_JUMP_1A       8'h14
`define OFS_BASE_FREQ     8'h2C
`define OFS_BASE_VOLT     8'h30
`define OFS_SECOND_BASE   8'h34
`define OFS_CONTROL       8'h38
`define OFS_SUPPLY_VOLT   8'h3C
`define OFS_RATED_VOLT    8'h40
`define OFS_RATED_FREQ    8'h44
`define OFS_FREQ_OUT      8'h48
`define OFS_VOLT_OUT      8'h4C
`define OFS_INFLECT       8'h50
// control register fields
`define CTL_LOAD_LSB      0
`define CTL_ACCEL_LSB     2
`define CTL_UGROUP_LSB    4
`define CTL_VECTOR_BIT    8
// settings in units of 0.01 Hz and 1 V; codes as printed
`define FREQ_120HZ        16'h2EE0
`define FREQ_400HZ        16'h9C40
`define FREQ_60HZ         16'h1770
`define FREQ_0HZ          16'h0000
`define CODE_9999         16'h270F
`define CODE_8888         16'h22B8
`define VOLT_1000V        16'h03E8
`define SUPPLY_RESET      16'h00C8
`define RATED_VOLT_RESET  16'h00C8
`define START_FREQ_RESET  16'h0032
`define JOG_FREQ_RESET    16'h01F4
`define RAMP_STEP         16'h0001
`endif

// >>> vf_limit_pkg.sv
// types for the frequency limit and v/f pattern block
package vf_limit_pkg;
  typedef enum logic [1:0] {RAMP_IDLE, RAMP_MOVE, RAMP_SETTLED} ramp_type;
  typedef struct packed {
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] hs_upper;
    logic [15:0] jog;
    logic [15:0] start_f;
    logic [5:0][15:0] jump;
    logic [15:0] base_f;
    logic [15:0] base_v;
    logic [15:0] second_base;
    logic [1:0]  load_sel;
    logic [1:0]  accel_sel;
    logic [3:0]  ugroup;
    logic        vector_mode;
    logic [15:0] supply_v;
    logic [15:0] rated_v;
    logic [15:0] rated_f;
  } settings_type;
  typedef struct packed {
    logic        aw_done;
    logic [7:0]  aw_addr;
    logic        w_done;
    logic [31:0] w_data;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } bus_type;
  typedef struct packed {
    settings_type cfg;
    bus_type      bus;
    ramp_type     ramp;
    logic [15:0]  freq;
    logic [15:0]  volt;
    logic [15:0]  boost;
    logic [15:0]  inflect;
  } state_type;
endpackage

// >>> vf_limit.sv
// frequency clamp, jump bands and v/f pattern with axi4-lite settings
`timescale 1ns/1ps
`default_nettype none
`include "vf_limit_params.svh"
module vf_limit
  import vf_limit_pkg::*;
(
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RESET,
  input  wire logic [15:0] I_FREQ_CMD,
  input  wire logic        I_CMD_VALID,
  input  wire logic        I_START,
  input  wire logic        I_JOG,
  input  wire logic        I_REVERSE,
  input  wire logic        I_SECOND_FUNCTION,
  input  wire logic        I_STALL_REDUCE,
  input  wire logic [15:0] I_STALL_FREQ,
  input  wire logic        I_UPDATE,
  input  wire logic [15:0] I_BOOST,
  input  wire logic [15:0] I_SECOND_BOOST,
  input  wire logic [7:0]  I_AWADDR,
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  output logic [1:0]       O_BRESP,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  input  wire logic [7:0]  I_ARADDR,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  output logic [15:0]      O_FREQ_OUT,
  output logic [15:0]      O_VOLT_OUT,
  output logic [15:0]      O_BOOST_OUT,
  output logic [15:0]      O_INFLECT_FREQ
);

  state_type   state_r;
  state_type   state_nxt;

  // ----------------------------------------------------------------
  // jump band detection
  // ----------------------------------------------------------------
  logic [2:0]  in_band;
  logic [15:0] band_a [3];

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_band
      logic [15:0] ba;
      logic [15:0] bb;
      logic [15:0] lo;
      logic [15:0] hi;
      assign ba = state_r.cfg.jump[2*g];
      assign bb = state_r.cfg.jump[2*g+1];
      assign lo = (ba < bb) ? ba : bb;
      assign hi = (ba < bb) ? bb : ba;
      assign band_a[g] = ba;
      assign in_band[g] = (ba != `CODE_9999) && (bb != `CODE_9999) &&
                          (I_FREQ_CMD >= lo) && (I_FREQ_CMD <= hi);
    end
  endgenerate

  // ----------------------------------------------------------------
  // conditioned reference and v/f
  // ----------------------------------------------------------------
  logic [15:0] jumped;
  logic [15:0] floor_f;
  logic [15:0] target;
  logic [15:0] base_act;
  logic [15:0] vmax;
  logic [31:0] lin;
  logic [47:0] sq;
  logic [15:0] v_pat;
  logic        ugroup_zero;
  logic [31:0] wval;
  logic [31:0] rd_word;
  logic        rd_hit;

  always_comb begin
    jumped = I_FREQ_CMD;
    if (in_band[0]) begin
      jumped = band_a[0];
    end else if (in_band[1]) begin
      jumped = band_a[1];
    end else if (in_band[2]) begin
      jumped = band_a[2];
    end
    floor_f = state_r.cfg.lower;
    if (I_JOG && state_r.cfg.jog <= state_r.cfg.lower) begin
      floor_f = state_r.cfg.jog;
    end
    if (!I_CMD_VALID && I_START && state_r.cfg.lower >= state_r.cfg.start_f) begin
      target = state_r.cfg.lower;
    end else if (!I_CMD_VALID || !I_START) begin
      target = `FREQ_0HZ;
    end else begin
      target = jumped;
      if (target < floor_f) begin
        target = floor_f;
      end
      if (target > state_r.cfg.upper) begin
        target = state_r.cfg.upper;
      end
    end
    if (I_JOG && !I_CMD_VALID) begin
      target = floor_f;
    end
    base_act = state_r.cfg.base_f;
    if (I_SECOND_FUNCTION && state_r.cfg.second_base != `CODE_9999) begin
      base_act = state_r.cfg.second_base;
    end
    if (state_r.cfg.base_v == `CODE_9999) begin
      vmax = state_r.cfg.supply_v;
    end else if (state_r.cfg.base_v == `CODE_8888) begin
      vmax = 16'((32'(state_r.cfg.supply_v) * 32'd95) / 32'd100);
    end else if (state_r.cfg.base_v < state_r.cfg.supply_v) begin
      vmax = state_r.cfg.base_v;
    end else begin
      vmax = state_r.cfg.supply_v;
    end
    if (state_r.cfg.vector_mode) begin
      base_act = state_r.cfg.rated_f;
      vmax = state_r.cfg.rated_v;
    end
    lin = 32'd0;
    sq = 48'd0;
    v_pat = vmax;
    if (base_act != 16'h0000 && state_r.freq < base_act) begin
      lin = (32'(vmax) * 32'(state_r.freq)) / 32'(base_act);
      sq = (48'(vmax) * 48'(state_r.freq) * 48'(state_r.freq)) /
           (48'(base_act) * 48'(base_act));
      if (state_r.cfg.load_sel == 2'd1 && !state_r.cfg.vector_mode) begin
        v_pat = sq[15:0];
      end else begin
        v_pat = lin[15:0];
      end
    end
    ugroup_zero = (state_r.cfg.ugroup == 4'h0);
    wval = state_r.bus.w_data;
    rd_hit = 1'b1;
    case (I_ARADDR)
      `OFS_UPPER_LIMIT: rd_word = {16'h0000, state_r.cfg.upper};
      `OFS_LOWER_LIMIT: rd_word = {16'h0000, state_r.cfg.lower};
      `OFS_HS_UPPER:    rd_word = {16'h0000, state_r.cfg.hs_upper};
      `OFS_JOG_FREQ:    rd_word = {16'h0000, state_r.cfg.jog};
      `OFS_START_FREQ:  rd_word = {16'h0000, state_r.cfg.start_f};
      `OFS_BASE_FREQ:   rd_word = {16'h0000, state_r.cfg.base_f};
      `OFS_BASE_VOLT:   rd_word = {16'h0000, state_r.cfg.base_v};
      `OFS_SECOND_BASE: rd_word = {16'h0000, state_r.cfg.second_base};
      `OFS_CONTROL:     rd_word = {23'h000000, state_r.cfg.vector_mode, state_r.cfg.ugroup,
                                   state_r.cfg.accel_sel, state_r.cfg.load_sel};
      `OFS_SUPPLY_VOLT: rd_word = {16'h0000, state_r.cfg.supply_v};
      `OFS_RATED_VOLT:  rd_word = {16'h0000, state_r.cfg.rated_v};
      `OFS_RATED_FREQ:  rd_word = {16'h0000, state_r.cfg.rated_f};
      `OFS_FREQ_OUT:    rd_word = {16'h0000, state_r.freq};
      `OFS_VOLT_OUT:    rd_word = {16'h0000, state_r.volt};
      `OFS_INFLECT:     rd_word = {16'h0000, state_r.inflect};
      default: begin
        rd_word = 32'h00000000;
        rd_hit = 1'b0;
        if (I_ARADDR >= `OFS_JUMP_1A && I_ARADDR < `OFS_BASE_FREQ && I_ARADDR[1:0] == 2'b00) begin
          rd_word = {16'h0000, state_r.cfg.jump[3'((I_ARADDR - `OFS_JUMP_1A) >> 2)]};
          rd_hit = 1'b1;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [2:0] jidx;
  logic       wr_go;

  always_comb begin
    state_nxt = state_r;
    jidx = 3'((state_r.bus.aw_addr - `OFS_JUMP_1A) >> 2);
    wr_go = state_r.bus.aw_done && state_r.bus.w_done && !state_r.bus.bvalid;
    // axi write channels
    if (I_AWVALID && !state_r.bus.aw_done && !state_r.bus.bvalid) begin
      state_nxt.bus.aw_done = 1'b1;
      state_nxt.bus.aw_addr = I_AWADDR;
    end
    if (I_WVALID && !state_r.bus.w_done && !state_r.bus.bvalid) begin
      state_nxt.bus.w_done = 1'b1;
      state_nxt.bus.w_data = I_WDATA;
    end
    if (wr_go) begin
      state_nxt.bus.aw_done = 1'b0;
      state_nxt.bus.w_done = 1'b0;
      state_nxt.bus.bvalid = 1'b1;
      state_nxt.bus.bresp = 2'b00;
      case (state_r.bus.aw_addr)
        `OFS_UPPER_LIMIT: begin
          if (wval[15:0] <= `FREQ_120HZ) begin
            state_nxt.cfg.upper = wval[15:0];
            state_nxt.cfg.hs_upper = wval[15:0];
          end
        end
        `OFS_LOWER_LIMIT: begin
          if (wval[15:0] <= `FREQ_120HZ) begin
            state_nxt.cfg.lower = wval[15:0];
          end
        end
        `OFS_HS_UPPER: begin
          if (ugroup_zero && wval[15:0] >= `FREQ_120HZ && wval[15:0] <= `FREQ_400HZ) begin
            state_nxt.cfg.hs_upper = wval[15:0];
            state_nxt.cfg.upper = wval[15:0];
          end
        end
        `OFS_JOG_FREQ:    state_nxt.cfg.jog = wval[15:0];
        `OFS_START_FREQ:  state_nxt.cfg.start_f = wval[15:0];
        `OFS_BASE_FREQ: begin
          if (wval[15:0] <= `FREQ_400HZ) begin
            state_nxt.cfg.base_f = wval[15:0];
          end
        end
        `OFS_BASE_VOLT: begin
          if (ugroup_zero && (wval[15:0] <= `VOLT_1000V || wval[15:0] == `CODE_8888 ||
                              wval[15:0] == `CODE_9999)) begin
            state_nxt.cfg.base_v = wval[15:0];
          end
        end
        `OFS_SECOND_BASE: begin
          if (ugroup_zero && (wval[15:0] <= `FREQ_400HZ || wval[15:0] == `CODE_9999)) begin
            state_nxt.cfg.second_base = wval[15:0];
          end
        end
        `OFS_CONTROL: begin
          if (ugroup_zero) begin
            state_nxt.cfg.load_sel = wval[`CTL_LOAD_LSB +: 2];
          end
          state_nxt.cfg.accel_sel = wval[`CTL_ACCEL_LSB +: 2];
          state_nxt.cfg.ugroup = wval[`CTL_UGROUP_LSB +: 4];
          state_nxt.cfg.vector_mode = wval[`CTL_VECTOR_BIT];
        end
        `OFS_SUPPLY_VOLT: state_nxt.cfg.supply_v = wval[15:0];
        `OFS_RATED_VOLT:  state_nxt.cfg.rated_v = wval[15:0];
        `OFS_RATED_FREQ:  state_nxt.cfg.rated_f = wval[15:0];
        default: begin
          if (state_r.bus.aw_addr >= `OFS_JUMP_1A && state_r.bus.aw_addr < `OFS_BASE_FREQ &&
              state_r.bus.aw_addr[1:0] == 2'b00) begin
            if (ugroup_zero && (wval[15:0] <= `FREQ_400HZ || wval[15:0] == `CODE_9999)) begin
              state_nxt.cfg.jump[jidx] = wval[15:0];
            end
          end else begin
            state_nxt.bus.bresp = 2'b10;
          end
        end
      endcase
    end
    if (state_r.bus.bvalid && I_BREADY) begin
      state_nxt.bus.bvalid = 1'b0;
    end
    // axi read
    if (I_ARVALID && !state_r.bus.rvalid) begin
      state_nxt.bus.rvalid = 1'b1;
      state_nxt.bus.rdata = rd_word;
      state_nxt.bus.rresp = rd_hit ? 2'b00 : 2'b10;
    end else if (state_r.bus.rvalid && I_RREADY) begin
      state_nxt.bus.rvalid = 1'b0;
    end
    // ramp toward the reference once per update; stall reduction loads I_STALL_FREQ directly
    if (I_UPDATE) begin
      if (I_STALL_REDUCE) begin
        state_nxt.freq = I_STALL_FREQ;
        state_nxt.ramp = RAMP_MOVE;
      end else if (state_r.freq < target) begin
        state_nxt.freq = state_r.freq + `RAMP_STEP;
        state_nxt.ramp = RAMP_MOVE;
      end else if (state_r.freq > target) begin
        state_nxt.freq = state_r.freq - `RAMP_STEP;
        state_nxt.ramp = RAMP_MOVE;
      end else begin
        state_nxt.freq = target;
        state_nxt.ramp = (target == `FREQ_0HZ) ? RAMP_IDLE : RAMP_SETTLED;
      end
      state_nxt.volt = v_pat;
      state_nxt.boost = I_SECOND_FUNCTION ? I_SECOND_BOOST : I_BOOST;
      if (!state_r.cfg.vector_mode &&
          ((state_r.cfg.load_sel == 2'd2 && I_REVERSE) ||
           (state_r.cfg.load_sel == 2'd3 && !I_REVERSE))) begin
        state_nxt.boost = 16'h0000;
      end
      state_nxt.inflect = (state_r.cfg.accel_sel == 2'd1) ?
                          (I_SECOND_FUNCTION && state_r.cfg.second_base != `CODE_9999 ?
                           state_r.cfg.second_base : state_r.cfg.base_f) : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      state_r <= '0;
      state_r.cfg.upper <= `FREQ_120HZ;
      state_r.cfg.hs_upper <= `FREQ_120HZ;
      state_r.cfg.lower <= `FREQ_0HZ;
      state_r.cfg.jog <= `JOG_FREQ_RESET;
      state_r.cfg.start_f <= `START_FREQ_RESET;
      state_r.cfg.jump <= {6{`CODE_9999}};
      state_r.cfg.base_f <= `FREQ_60HZ;
      state_r.cfg.base_v <= `CODE_9999;
      state_r.cfg.second_base <= `CODE_9999;
      state_r.cfg.load_sel <= 2'd0;
      state_r.cfg.supply_v <= `SUPPLY_RESET;
      state_r.cfg.rated_v <= `RATED_VOLT_RESET;
      state_r.cfg.rated_f <= `FREQ_60HZ;
      state_r.ramp <= RAMP_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign O_AWREADY = !state_r.bus.aw_done && !state_r.bus.bvalid;
  assign O_WREADY = !state_r.bus.w_done && !state_r.bus.bvalid;
  assign O_BVALID = state_r.bus.bvalid;
  assign O_BRESP = state_r.bus.bresp;
  assign O_ARREADY = !state_r.bus.rvalid;
  assign O_RVALID = state_r.bus.rvalid;
  assign O_RDATA = state_r.bus.rdata;
  assign O_RRESP = state_r.bus.rresp;
  assign O_FREQ_OUT = state_r.freq;
  assign O_VOLT_OUT = state_r.volt;
  assign O_BOOST_OUT = state_r.boost;
  assign O_INFLECT_FREQ = state_r.inflect;

endmodule
`default_nettype wire

// >>> vf_limit_assertions.sv
// port checker for the frequency limit and v/f pattern block
`timescale 1ns/1ps
`default_nettype none
module vf_limit_checker (
  input wire logic        I_SYS_CLK,
  input wire logic        I_RESET,
  input wire logic        I_UPDATE,
  input wire logic        I_STALL_REDUCE,
  input wire logic [15:0] I_STALL_FREQ,
  input wire logic        I_AWVALID,
  input wire logic        O_AWREADY,
  input wire logic        I_WVALID,
  input wire logic        O_WREADY,
  input wire logic        O_BVALID,
  input wire logic        I_BREADY,
  input wire logic        I_ARVALID,
  input wire logic        O_ARREADY,
  input wire logic        O_RVALID,
  input wire logic        I_RREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic [15:0] O_FREQ_OUT,
  input wire logic [15:0] O_VOLT_OUT
);
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_RESET);
  // ----------------------------------------
  // output pacing and frequency steps
  // ----------------------------------------
  out_hold_a: assert property (!I_UPDATE |=>
    $stable(O_FREQ_OUT) && $stable(O_VOLT_OUT))
    else $error("outputs changed without update");
  stall_force_a: assert property (I_UPDATE && I_STALL_REDUCE |=>
    O_FREQ_OUT == $past(I_STALL_FREQ))
    else $error("stall frequency not taken");
  ramp_step_a: assert property (I_UPDATE && !I_STALL_REDUCE |=>
    O_FREQ_OUT == $past(O_FREQ_OUT) || O_FREQ_OUT == $past(O_FREQ_OUT) + 16'h0001
    || O_FREQ_OUT == $past(O_FREQ_OUT) - 16'h0001)
    else $error("frequency stepped by more than one");
  // ----------------------------------------
  // register bus handshakes
  // ----------------------------------------
  bvalid_hold_a: assert property (O_BVALID && !I_BREADY |=> O_BVALID)
    else $error("write response dropped early");
  rdata_hold_a: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data dropped early");
  aw_block_a: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
    else $error("write accepted while response pending");
  read_lat_a: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read answer late");
  write_lat_a: assert property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY
    |-> ##[1:2] O_BVALID)
    else $error("write answer late");
  reset_clear_a: assert property (disable iff (1'b0) I_RESET |=>
    !O_BVALID && !O_RVALID && O_FREQ_OUT == 16'h0000)
    else $error("reset did not clear outputs");
  stall_c: cover property (I_UPDATE && I_STALL_REDUCE);
  write_c: cover property (O_BVALID && I_BREADY);
  read_c: cover property (O_RVALID && I_RREADY);
endmodule
bind vf_limit vf_limit_checker checker_i (.I_SYS_CLK, .I_RESET, .I_UPDATE, .I_STALL_REDUCE,
  .I_STALL_FREQ, .I_AWVALID, .O_AWREADY, .I_WVALID, .O_WREADY, .O_BVALID, .I_BREADY,
  .I_ARVALID, .O_ARREADY, .O_RVALID, .I_RREADY, .O_RDATA, .O_FREQ_OUT, .O_VOLT_OUT);
`default_nettype wire

// >>> vf_stage_model.sv
// power stage model pacing control updates, prompt or slow
`timescale 1ns/1ps
`default_nettype none
module vf_stage_model (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_slow,
  output logic      o_update
);
  logic [1:0] cnt_r;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cnt_r <= 2'h0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
    end
  end
  // one-cycle pulse every second or every fourth cycle
  assign o_update = !i_reset && (i_slow ? cnt_r == 2'h3 : cnt_r[0]);
endmodule
`default_nettype wire

// >>> tb_top.sv
// self-checking testbench for the frequency limit and v/f pattern block
`timescale 1ns/1ps
`default_nettype none
`include "vf_limit_params.svh"
module tb_top;
  logic        clk = 0;
  logic        rst = 1;
  logic [15:0] cmd, stall_f;
  logic        cmd_v, start, jog, rev, sf, stall, slow;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [15:0] f_out, v_out, b_out, infl;
  wire         upd;
  int          mismatches = 0;
  int          tests_run = 0;
  logic [7:0]  ofs [10] = '{`OFS_UPPER_LIMIT, `OFS_LOWER_LIMIT, `OFS_HS_UPPER, `OFS_JUMP_1A,
    8'h28, `OFS_BASE_FREQ, `OFS_BASE_VOLT, `OFS_SECOND_BASE, `OFS_CONTROL, `OFS_INFLECT};
  logic [15:0] rv [10] = '{`FREQ_120HZ, `FREQ_0HZ, `FREQ_120HZ, `CODE_9999, `CODE_9999,
    `FREQ_60HZ, `CODE_9999, `CODE_9999, 16'h0000, 16'h0000};
  logic [15:0] bx [5] = '{16'h0005, 16'h0007, 16'h0000, 16'h0005, 16'h0000};
  always #20 clk = ~clk;
  vf_stage_model stage (.i_clk(clk), .i_reset(rst), .i_slow(slow), .o_update(upd));
  vf_limit uut (.I_SYS_CLK(clk), .I_RESET(rst), .I_FREQ_CMD(cmd), .I_CMD_VALID(cmd_v),
    .I_START(start), .I_JOG(jog), .I_REVERSE(rev), .I_SECOND_FUNCTION(sf),
    .I_STALL_REDUCE(stall), .I_STALL_FREQ(stall_f), .I_UPDATE(upd), .I_BOOST(16'h0005),
    .I_SECOND_BOOST(16'h0007), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
    .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
    .I_RREADY(rready), .O_FREQ_OUT(f_out), .O_VOLT_OUT(v_out), .O_BOOST_OUT(b_out),
    .O_INFLECT_FREQ(infl));
  // ----------------------------------------
  // compare, bus and wait tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    bit aw = 0;
    bit w = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (!aw && awready) begin
        aw = 1;
        awvalid <= 0;
      end
      if (!w && wready) begin
        w = 1;
        wvalid <= 0;
      end
    end
    do @(posedge clk); while (!bvalid);
    bready <= 0;
    chk("bresp", bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge clk); while (!arready);
    arvalid <= 0;
    do @(posedge clk); while (!rvalid);
    rready <= 0;
    chk("rresp", rresp, er);
    if (er == 2'b00) chk("rdata", rdata, {16'h0000, ed});
  endtask
  task automatic run_to(input logic [15:0] e);
    int n = 0;
    while (f_out !== e && n < 2000) begin
      @(posedge clk);
      n++;
    end
    repeat (16) @(posedge clk);
    chk("freq", f_out, e);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {cmd, stall_f, cmd_v, start, jog, rev, sf, stall, slow} = '0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (12) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 10; i++) begin
      rd(ofs[i], rv[i], 2'b00);
    end
    rd(8'h54, 16'h0000, 2'b10);
    wr(8'h58, 16'h0001, 2'b10);
    wr(`OFS_UPPER_LIMIT, 16'h1388, 2'b00);
    rd(`OFS_HS_UPPER, 16'h1388, 2'b00);
    wr(`OFS_HS_UPPER, 16'h7530, 2'b00);
    rd(`OFS_UPPER_LIMIT, 16'h7530, 2'b00);
    wr(`OFS_LOWER_LIMIT, 16'h2EE1, 2'b00);
    rd(`OFS_LOWER_LIMIT, 16'h0000, 2'b00);
    wr(`OFS_CONTROL, 16'h0010, 2'b00);
    wr(`OFS_BASE_VOLT, 16'h0064, 2'b00);
    rd(`OFS_BASE_VOLT, `CODE_9999, 2'b00);
    wr(`OFS_CONTROL, 16'h0000, 2'b00);
    wr(`OFS_UPPER_LIMIT, 16'h00C8, 2'b00);
    wr(`OFS_LOWER_LIMIT, 16'h0064, 2'b00);
    wr(`OFS_BASE_FREQ, 16'h00C8, 2'b00);
    wr(`OFS_JOG_FREQ, 16'h0050, 2'b00);
    start <= 1;
    run_to(16'h0064);
    cmd <= 16'h1388;
    cmd_v <= 1;
    run_to(16'h00C8);
    chk("volt", v_out, 16'h00C8);
    chk("boost", b_out, 16'h0005);
    wr(`OFS_BASE_VOLT, `CODE_8888, 2'b00);
    run_to(16'h00C8);
    chk("volt", v_out, 16'h00BE);
    wr(`OFS_BASE_VOLT, 16'h0064, 2'b00);
    run_to(16'h00C8);
    chk("volt", v_out, 16'h0064);
    wr(`OFS_BASE_VOLT, `CODE_9999, 2'b00);
    cmd <= 16'h0010;
    run_to(16'h0064);
    chk("volt", v_out, 16'h0064);
    wr(`OFS_CONTROL, 16'h0001, 2'b00);
    run_to(16'h0064);
    chk("volt", v_out, 16'h0032);
    wr(`OFS_RATED_FREQ, 16'h0190, 2'b00);
    wr(`OFS_CONTROL, 16'h0101, 2'b00);
    run_to(16'h0064);
    chk("volt", v_out, 16'h0032);
    wr(`OFS_SECOND_BASE, 16'h0190, 2'b00);
    wr(`OFS_CONTROL, 16'h0004, 2'b00);
    sf <= 1;
    run_to(16'h0064);
    chk("volt", v_out, 16'h0032);
    chk("inflect", infl, 16'h0190);
    sf <= 0;
    run_to(16'h0064);
    chk("inflect", infl, 16'h00C8);
    for (int i = 0; i < 5; i++) begin
      wr(`OFS_CONTROL, i < 3 ? 16'h0002 : 16'h0003, 2'b00);
      rev <= i == 2 || i == 3;
      sf <= i == 1;
      run_to(16'h0064);
      chk("boost", b_out, bx[i]);
    end
    {rev, sf} <= 2'b00;
    jog <= 1;
    run_to(16'h0050);
    jog <= 0;
    stall_f <= 16'h0020;
    stall <= 1;
    run_to(16'h0020);
    stall <= 0;
    slow <= 1;
    wr(`OFS_JUMP_1A, 16'h0080, 2'b00);
    wr(`OFS_JUMP_1A + 8'h04, 16'h00A0, 2'b00);
    wr(`OFS_JUMP_1A + 8'h08, 16'h0040, 2'b00);
    wr(`OFS_JUMP_1A + 8'h0C, 16'h0070, 2'b00);
    cmd <= 16'h0090;
    run_to(16'h0080);
    cmd <= 16'h00B0;
    run_to(16'h00B0);
    cmd <= 16'h0068;
    run_to(16'h0064);
    rst <= 1;
    repeat (12) @(posedge clk);
    rst <= 0;
    rd(`OFS_UPPER_LIMIT, `FREQ_120HZ, 2'b00);
    conclude();
  end
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
